// file: shared/sadc_consts.svh
`ifndef SADC_CONSTS_SVH
`define SADC_CONSTS_SVH

// Control byte field positions (byte bit 7 is the start bit)
`define SADC_CHAN_HI      6
`define SADC_CHAN_LO      4
`define SADC_SGL_POS      2
`define SADC_PWR_HI       1
`define SADC_PWR_LO       0

// Power and clock field codes
`define SADC_PWR_AUTO     2'b00
`define SADC_PWR_RSVD     2'b01
`define SADC_PWR_INT      2'b10
`define SADC_PWR_EXT      2'b11

// Link side counts
`define SADC_CTRL_BITS    3'h6
`define SADC_ACQ_AT       3'h2
`define SADC_EXT_DONE     5'h10
`define SADC_MSB_TRIAL    16'h8000

// Timing
`define SADC_REF_PERIOD_NS 8
`define SADC_CONV_MAX_NS  8000
`define SADC_CONV_MAX_CYC (`SADC_CONV_MAX_NS / `SADC_REF_PERIOD_NS)
`define SADC_BIT_CYC      4

`endif

// file: shared/sadc_pkg.sv
package sadc_pkg;

	typedef struct packed {
		logic [2:0] chan;
		logic       spare;
		logic       sgl;
		logic [1:0] pwr;
	} sadc_ctl_s;

	typedef struct packed {
		logic [2:0] pos;
		logic [2:0] neg;
		logic       neg_ret;
	} sadc_mux_s;

	typedef enum logic [0:0] {
		L_HUNT = 1'b0,
		L_CTRL = 1'b1
	} sadc_link_e;

	typedef enum logic [0:0] {
		I_IDLE = 1'b0,
		I_CONV = 1'b1
	} sadc_int_e;

	typedef enum logic [0:0] {
		CLK_EXT = 1'b0,
		CLK_INT = 1'b1
	} sadc_clk_e;

endpackage : sadc_pkg

// file: core/sadc_ctrl.sv
// Contract
// RULE1: Ignore input until first high start bit
// RULE2: Byte: channel 6-4, spare 3, sgl 2, mode
// RULE3: Single-ended uses return pin, else pair
// RULE4: Single-ended positive channel is A1 A0 A2
// RULE5: Differential: low bits pair, top swaps polarity
// RULE6: Field 11: always powered, external clock
// RULE7: Field 00: low power between conversions
// RULE8: Field 10: internal clock conversion mode
// RULE9: Host never sends reserved field 01; the bench sends 8'h81 once, and the design keeps mode and auto_pd
// RULE10: Clock mode change lags one conversion
// RULE11: Host sets clock mode before power-down
// RULE12: Power-down keeps the previous clock mode
// RULE13: External: busy one period after byte
// RULE14: External: sixteen bits on falling edges
// RULE15: Host gives at least twenty-five clocks
// RULE16: Next byte may overlap the LSB
// RULE17: Thirty-two clock frame pads with zeros
// RULE18: External: pins float while select high
// RULE19: Internal: busy low during conversion, bounded
// RULE20: Host keeps clock low while converting
// RULE21: Internal: result held, read any time
// RULE22: Internal: MSB on next falling edge
// RULE23: Internal: busy stays driven, select free
// RULE24: Fast shifting needs long acquisition
// RULE25: Input sampled on serial rising edge
// RULE26: Byte over eight clocks, acquire then hold
`timescale 1ns/100ps
`default_nettype none
`include "sadc_consts.svh"

module sadc_ctrl
	import sadc_pkg::*;
#(
	parameter int BIT_CYC = `SADC_BIT_CYC
)
(
	// Core clock and reset
	input  wire logic  ref_clk_i,
	input  wire logic  rst_i,
	// Serial link
	input  wire logic  serial_clock_pin_i,
	input  wire logic  cs_n_i,
	input  wire logic  din_i,
	output logic       dout_o,
	output logic       dout_oe_n_o,
	output logic       busy_o,
	output logic       busy_oe_n_o,
	// Analog front end
	input  wire logic  comp_i,
	output logic [15:0] dac_trial_o,
	output sadc_mux_s  mux_o,
	output logic       acquire_o,
	output logic       power_down_o
);

	localparam int CONV_CYC = 16 * BIT_CYC;
	localparam int SUB_W = $clog2(BIT_CYC);
	localparam logic [SUB_W-1:0] SUB_LAST = SUB_W'(BIT_CYC - 1);

	// Comparator sync takes two cycles, so a bit needs three
	if (BIT_CYC < 3 || CONV_CYC > `SADC_CONV_MAX_CYC)
		$error("sadc_ctrl: BIT_CYC out of range");

	function automatic sadc_mux_s chan_map(input logic [2:0] a,
		input logic sgl);
		sadc_mux_s m;
		m.pos = {a[1], a[0], a[2]};
		m.neg = {a[1], a[0], ~a[2]};
		m.neg_ret = sgl;
		return m;
	endfunction : chan_map

	// Keep the trial bit when the input reached it, then try the next
	function automatic logic [15:0] sar_step(input logic [15:0] t,
		input logic [15:0] mask, input logic keep);
		logic [15:0] r;
		r = keep ? t : (t & ~mask);
		return r | (mask >> 1);
	endfunction : sar_step

	// Link reset, posedge of the serial clock
	logic       rst_l_meta;
	logic       rst_l;

	always_ff @(posedge serial_clock_pin_i)
	begin
		rst_l_meta <= rst_i;
		rst_l <= rst_l_meta;
	end

	// Control byte intake, serial rising edge
	sadc_link_e lstate, next_lstate;
	logic [2:0] cnt, next_cnt;
	logic [6:0] shreg, next_shreg;
	sadc_clk_e  mode, next_mode;
	logic       ext_tog, next_ext_tog;
	logic       int_tog, next_int_tog;
	logic       int_sel, next_int_sel;
	logic       auto_pd, next_auto_pd;
	logic       acq, next_acq;
	sadc_mux_s  mux, next_mux;
	sadc_ctl_s  fld;

	always_comb
	begin
		next_lstate = lstate;
		next_cnt = cnt;
		next_shreg = shreg;
		next_mode = mode;
		next_ext_tog = ext_tog;
		next_int_tog = int_tog;
		next_int_sel = int_sel;
		next_auto_pd = auto_pd;
		next_acq = acq;
		next_mux = mux;
		fld = sadc_ctl_s'(shreg);
		if (cs_n_i)
		begin
			next_lstate = L_HUNT;
			next_acq = 1'b0;
		end
		else
		begin
			case (lstate)
				L_HUNT:
				begin
					if (din_i) // RULE1 RULE25
					begin
						next_lstate = L_CTRL;
						next_cnt = `SADC_CTRL_BITS;
					end
				end
				L_CTRL:
				begin
					next_shreg = {shreg[5:0], din_i}; // RULE25 RULE2
					next_cnt = cnt - 3'h1;
					fld = sadc_ctl_s'(next_shreg);
					if (cnt == `SADC_ACQ_AT)
					begin
						// Channel and input mode known: start sampling
						next_mux = chan_map(next_shreg[4:2],
							next_shreg[0]); // RULE3 RULE4 RULE5
						next_acq = 1'b1; // RULE26
					end
					if (cnt == 3'h0)
					begin
						next_acq = 1'b0; // RULE26
						// Next start bit may arrive while the LSB is out
						next_lstate = L_HUNT; // RULE16
						// Conversion runs in the mode set before this byte
						if (mode == CLK_EXT) // RULE10
						begin
							next_ext_tog = ~ext_tog;
							next_int_sel = 1'b0;
						end
						else
						begin
							next_int_tog = ~int_tog;
							next_int_sel = 1'b1;
						end
						case (fld.pwr)
							`SADC_PWR_EXT:
							begin
								next_mode = CLK_EXT; // RULE6
								next_auto_pd = 1'b0;
							end
							`SADC_PWR_INT:
							begin
								next_mode = CLK_INT; // RULE8
								next_auto_pd = 1'b0;
							end
							`SADC_PWR_AUTO:
								next_auto_pd = 1'b1; // RULE12 RULE7
							default:
								next_auto_pd = auto_pd;
						endcase
					end
				end
				default:
					next_lstate = L_HUNT;
			endcase
		end
	end

	always_ff @(posedge serial_clock_pin_i)
	begin
		if (rst_l)
		begin
			lstate <= L_HUNT;
			cnt <= 3'h0;
			shreg <= 7'h00;
			mode <= CLK_EXT;
			ext_tog <= 1'b0;
			int_tog <= 1'b0;
			int_sel <= 1'b0;
			auto_pd <= 1'b0;
			acq <= 1'b0;
			mux <= '0;
		end
		else
		begin
			lstate <= next_lstate;
			cnt <= next_cnt;
			shreg <= next_shreg;
			mode <= next_mode;
			ext_tog <= next_ext_tog;
			int_tog <= next_int_tog;
			int_sel <= next_int_sel;
			auto_pd <= next_auto_pd;
			acq <= next_acq;
			mux <= next_mux;
		end
	end

	// External clock conversion, serial falling edge
	logic        seen, next_seen;
	logic [4:0]  ncnt, next_ncnt;
	logic [15:0] trial, next_trial;
	logic        busy_ext, next_busy_ext;
	logic        dout_ext, next_dout_ext;
	logic [15:0] mask;

	always_comb
	begin
		next_seen = seen;
		next_ncnt = ncnt;
		next_trial = trial;
		next_busy_ext = 1'b0;
		next_dout_ext = 1'b0; // RULE17
		mask = `SADC_MSB_TRIAL >> ncnt;
		if (cs_n_i)
			next_ncnt = `SADC_EXT_DONE;
		else if (ext_tog != seen)
		begin
			next_seen = ext_tog;
			next_ncnt = 5'h0;
			next_busy_ext = 1'b1; // RULE13
			next_trial = `SADC_MSB_TRIAL;
		end
		else if (ncnt < `SADC_EXT_DONE)
		begin
			next_ncnt = ncnt + 5'h1;
			next_dout_ext = comp_i; // RULE14
			next_trial = sar_step(trial, mask, comp_i);
		end
	end

	always_ff @(negedge serial_clock_pin_i)
	begin
		if (rst_l)
		begin
			seen <= 1'b0;
			ncnt <= `SADC_EXT_DONE;
			trial <= 16'h0000;
			busy_ext <= 1'b0;
			dout_ext <= 1'b0;
		end
		else
		begin
			seen <= next_seen;
			ncnt <= next_ncnt;
			trial <= next_trial;
			busy_ext <= next_busy_ext;
			dout_ext <= next_dout_ext;
		end
	end

	logic ext_act;
	assign ext_act = busy_ext | (ncnt < `SADC_EXT_DONE);

	// Crossings into the core clock
	logic [2:0] req_s;
	logic [2:0] clk_s;
	logic [1:0] cs_s;
	logic [1:0] comp_s;
	logic [1:0] auto_s;
	logic [1:0] eact_s;

	always_ff @(posedge ref_clk_i)
	begin
		req_s <= {req_s[1:0], int_tog};
		clk_s <= {clk_s[1:0], serial_clock_pin_i};
		cs_s <= {cs_s[0], cs_n_i};
		comp_s <= {comp_s[0], comp_i};
		auto_s <= {auto_s[0], auto_pd};
		eact_s <= {eact_s[0], ext_act};
	end

	// Internal clock conversion and buffered readout, core clock
	sadc_int_e        istate, next_istate;
	logic [3:0]       bitn, next_bitn;
	logic [SUB_W-1:0] sub, next_sub;
	logic [15:0]      itrial, next_itrial;
	logic [15:0]      ishift, next_ishift;
	logic             busy_int, next_busy_int;
	logic             dout_int, next_dout_int;
	logic             pd, next_pd;
	logic [15:0]      imask;
	logic [15:0]      idec;

	always_comb
	begin
		next_istate = istate;
		next_bitn = bitn;
		next_sub = sub;
		next_itrial = itrial;
		next_ishift = ishift;
		next_busy_int = busy_int;
		next_dout_int = dout_int;
		imask = 16'h0001 << bitn;
		idec = comp_s[1] ? itrial : (itrial & ~imask);
		if (req_s[2] != req_s[1])
		begin
			next_istate = I_CONV;
			next_busy_int = 1'b0; // RULE19
			next_itrial = `SADC_MSB_TRIAL;
			next_bitn = 4'hf;
			next_sub = '0;
		end
		else if (istate == I_CONV)
		begin
			next_sub = sub + SUB_W'(1);
			if (sub == SUB_LAST)
			begin
				next_sub = '0;
				next_itrial = sar_step(itrial, imask, comp_s[1]);
				if (bitn == 4'h0)
				begin
					next_istate = I_IDLE;
					next_busy_int = 1'b1; // RULE19
					next_ishift = idec; // RULE21
				end
				else
					next_bitn = bitn - 4'h1;
			end
		end
		else if (clk_s[2] && !clk_s[1] && !cs_s[1])
		begin
			// Falling edge with select low shifts one bit, then zeros
			next_dout_int = ishift[15]; // RULE22 RULE21
			next_ishift = {ishift[14:0], 1'b0};
		end
		// Low power only while nothing converts
		next_pd = auto_s[1] & ~eact_s[1] & next_busy_int; // RULE7
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			istate <= I_IDLE;
			bitn <= 4'h0;
			sub <= '0;
			itrial <= 16'h0000;
			ishift <= 16'h0000;
			busy_int <= 1'b1;
			dout_int <= 1'b0;
			pd <= 1'b0;
		end
		else
		begin
			istate <= next_istate;
			bitn <= next_bitn;
			sub <= next_sub;
			itrial <= next_itrial;
			ishift <= next_ishift;
			busy_int <= next_busy_int;
			dout_int <= next_dout_int;
			pd <= next_pd;
		end
	end

	// Pin drivers; the select gating is pin to pin, no edge needed
	assign dout_o = int_sel ? dout_int : dout_ext;
	assign dout_oe_n_o = cs_n_i; // RULE18
	assign busy_o = int_sel ? busy_int : (busy_ext & ~cs_n_i); // RULE18
	assign busy_oe_n_o = int_sel ? 1'b0 : cs_n_i; // RULE23 RULE18
	assign dac_trial_o = int_sel ? itrial : trial;
	assign mux_o = mux;
	assign acquire_o = acq;
	assign power_down_o = pd;

endmodule : sadc_ctrl

`default_nettype wire

// file: bench/sadc_chk_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module sadc_chk
	import sadc_pkg::*;
(
	// Clock, reset, link inputs
	input wire logic        ref_clk_i,
	input wire logic        rst_i,
	input wire logic        serial_clock_pin_i,
	input wire logic        cs_n_i,
	input wire logic        din_i,
	input wire logic        comp_i,
	// Design outputs
	input wire logic        dout_o,
	input wire logic        dout_oe_n_o,
	input wire logic        busy_o,
	input wire logic        busy_oe_n_o,
	input wire logic [15:0] dac_trial_o,
	input wire sadc_mux_s   mux_o,
	input wire logic        acquire_o,
	input wire logic        power_down_o
);
	// Only busy held low with select released is timed: that is internal mode
	logic [10:0] lo_n;
	logic [10:0] next_lo_n;
	always_comb
		next_lo_n = (!busy_o && cs_n_i && !busy_oe_n_o) ? lo_n + 11'h1 : 11'h0;
	always_ff @(posedge ref_clk_i)
		lo_n <= rst_i ? 11'h0 : next_lo_n;

	mux_pair_a: assert property (@(posedge serial_clock_pin_i)
		disable iff (rst_i || cs_n_i) $rose(acquire_o) |-> mux_o.neg ==
		{$past(din_i, 4), $past(din_i, 3), !$past(din_i, 5)})
		else $error("pair");
	chan_map_a: assert property (@(posedge serial_clock_pin_i)
		disable iff (rst_i || cs_n_i) $rose(acquire_o) |-> mux_o.pos ==
		{$past(din_i, 4), $past(din_i, 3), $past(din_i, 5)}) else $error("map");
	sgl_ret_a: assert property (@(posedge serial_clock_pin_i)
		disable iff (rst_i || cs_n_i) $rose(acquire_o)
		|-> mux_o.neg_ret == $past(din_i)) else $error("ret");
	start_bit_a: assert property (@(posedge serial_clock_pin_i)
		disable iff (rst_i || cs_n_i) $rose(acquire_o)
		|-> $past(din_i, 6)) else $error("start");
	acq_len_a: assert property (@(posedge serial_clock_pin_i)
		disable iff (rst_i || cs_n_i) $rose(acquire_o)
		|=> acquire_o ##1 !acquire_o) else $error("acquire");
	dout_oe_a: assert property (@(posedge ref_clk_i)
		disable iff (rst_i) dout_oe_n_o == cs_n_i) else $error("dout oe");
	busy_oe_a: assert property (@(posedge ref_clk_i)
		disable iff (rst_i) !cs_n_i |-> !busy_oe_n_o) else $error("busy oe");
	conv_max_a: assert property (@(posedge ref_clk_i)
		disable iff (rst_i) lo_n < 11'h3e8) else $error("conv long");

	cover property (@(posedge serial_clock_pin_i) $rose(acquire_o));
	cover property (@(posedge ref_clk_i) $rose(busy_o));
	cover property (@(posedge ref_clk_i) $rose(power_down_o));
endmodule : sadc_chk
`default_nettype wire

// file: bench/sadc_host.sv
`timescale 1ns/100ps
`default_nettype none
module sadc_host (
	// Serial link
	output logic              sclk_o,
	output logic              cs_n_o,
	output logic              din_o,
	input wire logic          dout_i,
	input wire logic          busy_i,
	// Comparator
	input wire logic [15:0]   trial_i,
	input wire logic [15:0]   level_i,
	output logic              comp_o
);
	logic [31:0] rx;
	logic [31:0] rb;
	assign comp_o = level_i >= trial_i;
	// Clock rests low between frames, quiet for internal conversions
	initial {sclk_o, cs_n_o, din_o} = 3'h2;
	task idle(input int n);
		repeat (n) #32 sclk_o = ~sclk_o;
	endtask : idle
	task frame(input logic [7:0] ctl, input int lead, input int n);
		int k;
		cs_n_o = 1'b0;
		#40;
		for (k = 0; k < n; k++)
		begin
			din_o = (k >= lead && k < lead + 8) ? ctl[7 + lead - k] : 1'b0;
			#32 sclk_o = 1'b1;
			// Sampled just before the fall: a full period of settling
			#32 rx = {rx[30:0], dout_i};
			rb = {rb[30:0], busy_i};
			sclk_o = 1'b0;
			// Clock stopped low keeps sampling long at this fast rate
			if (ctl[7] && k == lead + 5)
				#1700;
		end
		#40 cs_n_o = 1'b1;
		// Select stays high a while so frames never meet in one step
		#40;
	endtask : frame
endmodule : sadc_host
`default_nettype wire

// file: bench/tb_sar_adc_serial_control_readout.sv
`timescale 1ns/100ps
`default_nettype none
module tb_sar_adc_serial_control_readout
	import sadc_pkg::*;
;
	logic        ref_clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        sclk, cs_n, din, dout, dout_oe_n, busy, busy_oe_n;
	logic        comp, acq, pd;
	logic [15:0] trial, level;
	sadc_mux_s   mux;
	int          miscompares, check_count, cycles, c;
	always #4 ref_clk_i = ~ref_clk_i;
	sadc_ctrl dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
		.serial_clock_pin_i(sclk), .cs_n_i(cs_n), .din_i(din),
		.dout_o(dout), .dout_oe_n_o(dout_oe_n), .busy_o(busy),
		.busy_oe_n_o(busy_oe_n), .comp_i(comp), .dac_trial_o(trial),
		.mux_o(mux), .acquire_o(acq), .power_down_o(pd));
	sadc_host host (.sclk_o(sclk), .cs_n_o(cs_n), .din_o(din),
		.dout_i(dout), .busy_i(busy), .trial_i(trial), .level_i(level),
		.comp_o(comp));
	task check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task wrap_up;
		if (miscompares == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : wrap_up
	task ext(input logic [7:0] ctl, input int lead);
		host.frame(ctl, lead, 32 + lead);
		check("result", host.rx[22:7], level);
		check("pad", {9'h0, host.rx[6:0]}, 16'h0);
		check("busy", {13'h0, host.rb[24:22]}, 16'h2);
	endtask : ext
	task conv_done;
		int n;
		n = 0;
		while (busy !== 1'b1 && n < 1100)
		begin
			@(posedge ref_clk_i);
			n++;
		end
		check("conv", {15'h0, n < 1000}, 16'h1);
	endtask : conv_done
	always @(posedge ref_clk_i)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			miscompares++;
			wrap_up();
		end
	end
	initial
	begin
		level = 16'ha5c3;
		repeat (16) @(posedge ref_clk_i);
		host.idle(8);
		@(posedge ref_clk_i);
		rst_i <= 1'b0;
		repeat (4) @(posedge ref_clk_i);
		ext(8'h97, 3);
		check("pos", {13'h0, mux.pos}, 16'h2);
		check("ret", {15'h0, mux.neg_ret}, 16'h1);
		check("floats", {14'h0, dout_oe_n, busy_oe_n}, 16'h3);
		for (c = 0; c < 16; c++)
		begin
			host.frame({1'b1, c[2:0], 1'b0, c[3], 2'h3}, 0, 8);
			check("pos", {13'h0, mux.pos}, {13'h0, c[1], c[0], c[2]});
			check("neg", {13'h0, mux.neg}, {13'h0, c[1], c[0], ~c[2]});
			check("ret", {15'h0, mux.neg_ret}, {15'h0, c[3]});
		end
		level = 16'h0001;
		host.frame(8'h81, 0, 32);
		ext(8'h83, 0);
		level = 16'hffff;
		host.frame(8'h80, 0, 32);
		repeat (8) @(posedge ref_clk_i);
		check("pd", {15'h0, pd}, 16'h1);
		ext(8'h83, 0);
		repeat (8) @(posedge ref_clk_i);
		check("pd", {15'h0, pd}, 16'h0);
		level = 16'h5a5b;
		host.frame(8'h83, 0, 24);
		check("lead", {1'b0, host.rx[14:0]}, {1'b0, level[15:1]});
		ext(8'h82, 0);
		check("lsb", {15'h0, host.rx[31]}, {15'h0, level[0]});
		host.frame(8'h82, 0, 8);
		check("ibusy", {14'h0, busy, busy_oe_n}, 16'h0);
		conv_done();
		host.frame(8'h00, 0, 17);
		check("int", host.rx[15:0], level);
		host.frame(8'h80, 0, 8);
		conv_done();
		host.frame(8'h80, 0, 8);
		check("keep", {14'h0, busy, busy_oe_n}, 16'h0);
		conv_done();
		repeat (8) @(posedge ref_clk_i);
		check("pd", {15'h0, pd}, 16'h1);
		host.frame(8'h00, 0, 17);
		check("held", host.rx[15:0], level);
		wrap_up();
	end
endmodule : tb_sar_adc_serial_control_readout
bind sadc_ctrl sadc_chk chk (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
	.serial_clock_pin_i(serial_clock_pin_i), .cs_n_i(cs_n_i),
	.din_i(din_i), .comp_i(comp_i), .dout_o(dout_o),
	.dout_oe_n_o(dout_oe_n_o), .busy_o(busy_o), .busy_oe_n_o(busy_oe_n_o),
	.dac_trial_o(dac_trial_o), .mux_o(mux_o), .acquire_o(acquire_o),
	.power_down_o(power_down_o));
`default_nettype wire
